// >>> shared/mbdma_pkg.sv
// constants, register map and state types for the multi-buffer dma channel
`default_nettype none

package mbdma_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the wishbone slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] MBDMA_OFS_GLOBAL   = 8'h00; // global_enable_register
  localparam logic [7:0] MBDMA_OFS_CHAN     = 8'h04; // channel_enable_register / channel_status_register
  localparam logic [7:0] MBDMA_OFS_MASK     = 8'h08; // event_mask_register
  localparam logic [7:0] MBDMA_OFS_EVENT    = 8'h0C; // event status, cleared by read
  localparam logic [7:0] MBDMA_OFS_SRC      = 8'h10; // chan_source_pointer
  localparam logic [7:0] MBDMA_OFS_DST      = 8'h14; // chan_dest_pointer
  localparam logic [7:0] MBDMA_OFS_NEXT     = 8'h18; // next_descriptor_pointer
  localparam logic [7:0] MBDMA_OFS_CTL1     = 8'h1C; // control_word_one
  localparam logic [7:0] MBDMA_OFS_CTL2     = 8'h20; // control_word_two
  localparam logic [7:0] MBDMA_OFS_CFG      = 8'h24; // channel_config
  localparam logic [7:0] MBDMA_OFS_SSTRIDE  = 8'h28; // source_window_stride
  localparam logic [7:0] MBDMA_OFS_DSTRIDE  = 8'h2C; // dest_window_stride
  localparam logic [7:0] MBDMA_OFS_SWREQ    = 8'h30; // software handshake requests

  // ----------------------------------------------------------------
  // bit and field positions
  // ----------------------------------------------------------------
  localparam int MBDMA_ENABLE_BIT   = 0;  // global enable and channel enable
  localparam int MBDMA_KEEP_BIT     = 1;  // keep_going_bit in channel_enable_register
  localparam int MBDMA_BSIZE_LSB    = 0;  // buffer_size_count, 16 bits
  localparam int MBDMA_SSIZE_LSB    = 24; // source_word_size
  localparam int MBDMA_DSIZE_LSB    = 28; // dest_word_size
  localparam int MBDMA_DONE_BIT     = 31; // buffer finished flag
  localparam int MBDMA_SLAYER_LSB   = 0;  // source_layer_select
  localparam int MBDMA_DLAYER_LSB   = 4;  // dest_layer_select
  localparam int MBDMA_SWIN_BIT     = 8;  // source_window_on
  localparam int MBDMA_DWIN_BIT     = 12; // dest_window_on
  localparam int MBDMA_FLOW_LSB     = 21; // flow_owner_select, 3 bits
  localparam int MBDMA_SSTEP_LSB    = 24; // source_step_mode
  localparam int MBDMA_DSTEP_LSB    = 28; // dest_step_mode
  localparam int MBDMA_AUTO_BIT     = 31; // self-reload mode bit
  localparam int MBDMA_SHSEL_LSB    = 0;  // source_handshake_select, 4 bits
  localparam int MBDMA_DHSEL_LSB    = 4;  // dest_handshake_select, 4 bits
  localparam int MBDMA_SHTYPE_BIT   = 9;  // source_handshake_type
  localparam int MBDMA_DHTYPE_BIT   = 13; // dest_handshake_type
  localparam int MBDMA_SREPLAY_BIT  = 16; // source replay at buffer end
  localparam int MBDMA_DHOLD_BIT    = 17; // fetched destination is ignored
  localparam int MBDMA_JUMP_LSB     = 0;  // stride: extra jump, 16 bits
  localparam int MBDMA_BOUND_LSB    = 16; // stride: elements per line, 16 bits

  // ----------------------------------------------------------------
  // encodings and descriptor layout
  // ----------------------------------------------------------------
  localparam logic [1:0]  MBDMA_STEP_INC   = 2'h0;
  localparam logic [1:0]  MBDMA_STEP_DEC   = 2'h1;
  localparam logic [2:0]  MBDMA_FLOW_M2P   = 3'h1;
  localparam logic [2:0]  MBDMA_FLOW_P2M   = 3'h2;
  localparam logic [2:0]  MBDMA_FLOW_P2P   = 3'h3;
  localparam logic [2:0]  MBDMA_DESC_LAST  = 3'h4;  // index of the last descriptor word
  localparam logic [31:0] MBDMA_CTL1_OFS   = 32'h0000_0008;
  localparam logic [31:0] MBDMA_ZERO       = 32'h0000_0000;

  typedef enum logic [8:0] {
    MBDMA_IDLE  = 9'h001,
    MBDMA_FETCH = 9'h002,
    MBDMA_SWAIT = 9'h004,
    MBDMA_READ  = 9'h008,
    MBDMA_DWAIT = 9'h010,
    MBDMA_WRITE = 9'h020,
    MBDMA_WBACK = 9'h040,
    MBDMA_BEND  = 9'h080,
    MBDMA_STALL = 9'h100
  } mbdma_fsm_t;

  // master request carried to the system bus
  typedef struct packed {
    logic        cyc;
    logic        we;
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic [1:0]  layer;
  } mbdma_mreq_t;

  typedef struct packed {
    mbdma_fsm_t  fsm;
    logic        glob_en;
    logic        active;
    logic        stall;
    logic        mask;
    logic        ev_buf;
    logic        ev_chain;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] dscr;
    logic [31:0] ctl1;
    logic [31:0] ctl2;
    logic [31:0] cfg;
    logic [31:0] sstride;
    logic [31:0] dstride;
    logic [31:0] src_init;
    logic [31:0] desc_base;
    logic [1:0]  desc_layer;
    logic        desc_used;
    logic [2:0]  fidx;
    logic [15:0] cnt;
    logic [15:0] swin;
    logic [15:0] dwin;
    logic [31:0] data;
    logic [1:0]  swreq;
    logic [2:0]  sync_s;
    logic [2:0]  sync_d;
    logic        pend_s;
    logic        pend_d;
    mbdma_mreq_t mreq;
    logic        wb_ack;
    logic [31:0] wb_dat;
    logic        src_ack;
    logic        dst_ack;
  } mbdma_st_t;

endpackage

`default_nettype wire

// >>> src/mbdma_channel.sv
// one multi-buffer dma channel with wishbone registers and a bus master port
`default_nettype none

module mbdma_channel
  import mbdma_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output mbdma_mreq_t      m_req_o,
  input  wire logic [31:0] m_dat_i,
  input  wire logic        m_ack_i,
  input  wire logic        src_req_i,
  input  wire logic        dst_req_i,
  output logic             src_ack_o,
  output logic             dst_ack_o,
  output logic      [3:0]  src_hs_sel_o,
  output logic      [3:0]  dst_hs_sel_o,
  output logic             chan_active_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // next element address, with the window jump at each line end
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] sz, input logic [1:0] md,
                                            input logic win, input logic [31:0] stride, input logic [15:0] wc);
    logic [31:0] res;
    logic [31:0] step;
    step = 32'h0000_0001 << sz;
    if (md == MBDMA_STEP_INC)
      res = a + step;
    else if (md == MBDMA_STEP_DEC)
      res = a - step;
    else
      res = a;
    if (win && (16'(wc + 16'h0001) == stride[MBDMA_BOUND_LSB +: 16]))
      res = res + {16'h0000, stride[MBDMA_JUMP_LSB +: 16]};
    return res;
  endfunction

  function automatic logic [15:0] win_next(input logic win, input logic [31:0] stride, input logic [15:0] wc);
    logic [15:0] inc;
    inc = 16'(wc + 16'h0001);
    return (!win || inc == stride[MBDMA_BOUND_LSB +: 16]) ? 16'h0000 : inc;
  endfunction

  function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
    if (sz == 2'h0)
      return 4'h1 << a;
    else if (sz == 2'h1)
      return 4'h3 << {a[1], 1'b0};
    else
      return 4'hF;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mbdma_st_t   r;
  mbdma_st_t   n;
  logic [31:0] rd_val;
  logic        wb_hit;
  logic        set_buf;
  logic        set_chain;
  logic        source_handshake_select;
  logic        dest_handshake_select;
  logic        src_rdy;
  logic        dst_rdy;
  logic        is_last;
  logic        go_next;
  logic [1:0]  ssz;
  logic [1:0]  dsz;
  logic [31:0] elem;

  // field decode of the live channel copy
  always_comb
  begin
    ssz     = r.ctl1[MBDMA_SSIZE_LSB +: 2];
    dsz     = r.ctl1[MBDMA_DSIZE_LSB +: 2];
    source_handshake_select = (r.ctl2[MBDMA_FLOW_LSB +: 3] == MBDMA_FLOW_P2M) || (r.ctl2[MBDMA_FLOW_LSB +: 3] == MBDMA_FLOW_P2P);
    dest_handshake_select = (r.ctl2[MBDMA_FLOW_LSB +: 3] == MBDMA_FLOW_M2P) || (r.ctl2[MBDMA_FLOW_LSB +: 3] == MBDMA_FLOW_P2P);
    // memory sides never wait; peripherals use pin or software request
    src_rdy = !source_handshake_select || (r.cfg[MBDMA_SHTYPE_BIT] ? r.pend_s : r.swreq[0]);
    dst_rdy = !dest_handshake_select || (r.cfg[MBDMA_DHTYPE_BIT] ? r.pend_d : r.swreq[1]);
    // final row: no self-reload and no further descriptor
    is_last = !r.ctl2[MBDMA_AUTO_BIT] && (r.dscr[31:2] == 30'h0000_0000);
    elem    = m_dat_i >> {r.mreq.adr[1:0], 3'b000};
  end

  // register read mux
  always_comb
  begin
    case (wb_adr_i)
      MBDMA_OFS_GLOBAL:  rd_val = {31'h0000_0000, r.glob_en};
      MBDMA_OFS_CHAN:    rd_val = {30'h0000_0000, r.stall, r.active};
      MBDMA_OFS_MASK:    rd_val = {31'h0000_0000, r.mask};
      MBDMA_OFS_EVENT:   rd_val = {30'h0000_0000, r.ev_chain, r.ev_buf};
      MBDMA_OFS_SRC:     rd_val = r.src;
      MBDMA_OFS_DST:     rd_val = r.dst;
      MBDMA_OFS_NEXT:    rd_val = r.dscr;
      MBDMA_OFS_CTL1:    rd_val = r.ctl1;
      MBDMA_OFS_CTL2:    rd_val = r.ctl2;
      MBDMA_OFS_CFG:     rd_val = r.cfg;
      MBDMA_OFS_SSTRIDE: rd_val = r.sstride;
      MBDMA_OFS_DSTRIDE: rd_val = r.dstride;
      MBDMA_OFS_SWREQ:   rd_val = {30'h0000_0000, r.swreq};
      default:           rd_val = MBDMA_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n         = r;
    set_buf   = 1'b0;
    set_chain = 1'b0;
    go_next   = 1'b0;
    n.wb_ack  = 1'b0;
    n.src_ack = 1'b0;
    n.dst_ack = 1'b0;
    wb_hit    = wb_cyc_i && wb_stb_i && !r.wb_ack;

    // request pins: two-stage synchroniser, then rising-edge catch
    n.sync_s = {r.sync_s[1:0], src_req_i};
    n.sync_d = {r.sync_d[1:0], dst_req_i};

    // channel sequencer; all bus traffic shares one master port
    case (r.fsm)
      MBDMA_IDLE:
      begin
        n.mreq.cyc = 1'b0;
      end
      MBDMA_FETCH:
      begin
        if (!r.mreq.cyc)
        begin
          n.mreq.cyc   = 1'b1;
          n.mreq.we    = 1'b0;
          n.mreq.adr   = r.desc_base + {27'h0000000, r.fidx, 2'b00};
          n.mreq.sel   = 4'hF;
          n.mreq.layer = r.desc_layer;
        end
        else if (m_ack_i)
        begin
          n.mreq.cyc = 1'b0;
          n.fidx     = 3'(r.fidx + 3'h1);
          case (r.fidx)
            3'h0:    if (!r.cfg[MBDMA_SREPLAY_BIT]) n.src = m_dat_i;
            3'h1:    if (!r.cfg[MBDMA_DHOLD_BIT]) n.dst = m_dat_i;
            3'h2:    n.ctl1 = m_dat_i;
            3'h3:    n.ctl2 = m_dat_i;
            default: n.dscr = m_dat_i;
          endcase
          if (r.fidx == MBDMA_DESC_LAST)
          begin
            n.fsm       = MBDMA_SWAIT;
            n.cnt       = 16'h0000;
            n.desc_used = 1'b1;
          end
        end
      end
      MBDMA_SWAIT:
      begin
        if (r.cnt == r.ctl1[MBDMA_BSIZE_LSB +: 16])
          n.fsm = r.desc_used ? MBDMA_WBACK : MBDMA_BEND;
        else if (src_rdy)
        begin
          n.pend_s     = 1'b0;
          n.swreq[0]   = 1'b0;
          n.mreq.cyc   = 1'b1;
          n.mreq.we    = 1'b0;
          n.mreq.adr   = r.src;
          n.mreq.sel   = lanes(ssz, r.src[1:0]);
          n.mreq.layer = r.ctl2[MBDMA_SLAYER_LSB +: 2];
          n.fsm        = MBDMA_READ;
        end
      end
      MBDMA_READ:
      begin
        if (m_ack_i)
        begin
          n.mreq.cyc = 1'b0;
          n.data     = elem;
          n.src_ack  = source_handshake_select;
          n.src      = step_addr(r.src, ssz, r.ctl2[MBDMA_SSTEP_LSB +: 2], r.ctl2[MBDMA_SWIN_BIT],
                                 r.sstride, r.swin);
          n.swin     = win_next(r.ctl2[MBDMA_SWIN_BIT], r.sstride, r.swin);
          n.fsm      = MBDMA_DWAIT;
        end
      end
      MBDMA_DWAIT:
      begin
        if (dst_rdy)
        begin
          n.pend_d     = 1'b0;
          n.swreq[1]   = 1'b0;
          n.mreq.cyc   = 1'b1;
          n.mreq.we    = 1'b1;
          n.mreq.adr   = r.dst;
          n.mreq.dat   = r.data << {r.dst[1:0], 3'b000};
          n.mreq.sel   = lanes(dsz, r.dst[1:0]);
          n.mreq.layer = r.ctl2[MBDMA_DLAYER_LSB +: 2];
          n.fsm        = MBDMA_WRITE;
        end
      end
      MBDMA_WRITE:
      begin
        if (m_ack_i)
        begin
          n.mreq.cyc = 1'b0;
          n.dst_ack  = dest_handshake_select;
          n.dst      = step_addr(r.dst, dsz, r.ctl2[MBDMA_DSTEP_LSB +: 2], r.ctl2[MBDMA_DWIN_BIT],
                                 r.dstride, r.dwin);
          n.dwin     = win_next(r.ctl2[MBDMA_DWIN_BIT], r.dstride, r.dwin);
          n.cnt      = 16'(r.cnt + 16'h0001);
          n.fsm      = MBDMA_SWAIT;
        end
      end
      MBDMA_WBACK:
      begin
        if (!r.mreq.cyc)
        begin
          // only control word one goes back, with count and done set
          n.mreq.cyc   = 1'b1;
          n.mreq.we    = 1'b1;
          n.mreq.adr   = r.desc_base + MBDMA_CTL1_OFS;
          n.mreq.layer = r.desc_layer;
          n.mreq.sel   = 4'hF;
          n.mreq.dat   = {1'b1, r.ctl1[30:16], r.cnt};
          n.ctl1       = {1'b1, r.ctl1[30:16], r.cnt};
        end
        else if (m_ack_i)
        begin
          n.mreq.cyc = 1'b0;
          n.fsm      = MBDMA_BEND;
        end
      end
      MBDMA_BEND:
      begin
        set_buf = 1'b1;
        if (r.cfg[MBDMA_SREPLAY_BIT])
        begin
          n.src  = r.src_init;
          n.swin = 16'h0000;
        end
        if (is_last)
        begin
          set_chain = 1'b1;
          n.active  = 1'b0;
          n.fsm     = MBDMA_IDLE;
        end
        else if (r.mask)
        begin
          n.stall = 1'b1;
          n.fsm   = MBDMA_STALL;
        end
        else
          go_next = 1'b1;
      end
      MBDMA_STALL:
      begin
        go_next = !r.stall;
      end
      default:
      begin
        n.fsm = MBDMA_IDLE;
      end
    endcase

    // edge catch after the sequencer: a request in the consuming cycle is kept
    if (r.sync_s[1] && !r.sync_s[2])
      n.pend_s = 1'b1;
    if (r.sync_d[1] && !r.sync_d[2])
      n.pend_d = 1'b1;

    // next buffer: follow the chain or replay in place
    if (go_next)
    begin
      n.cnt       = 16'h0000;
      n.desc_used = 1'b0;
      if (r.dscr[31:2] != 30'h0000_0000)
      begin
        n.fsm        = MBDMA_FETCH;
        n.fidx       = 3'h0;
        n.desc_base  = {r.dscr[31:2], 2'b00};
        n.desc_layer = r.dscr[1:0];
      end
      else
        n.fsm = MBDMA_SWAIT;
    end

    // wishbone slave; writes merge by byte lane
    if (wb_hit)
    begin
      n.wb_ack = 1'b1;
      n.wb_dat = rd_val;
      if (!wb_we_i && wb_adr_i == MBDMA_OFS_EVENT)
      begin
        n.ev_buf   = 1'b0;
        n.ev_chain = 1'b0;
      end
      if (wb_we_i && wb_sel_i[0])
      begin
        case (wb_adr_i)
          MBDMA_OFS_GLOBAL: n.glob_en = wb_dat_i[MBDMA_ENABLE_BIT];
          MBDMA_OFS_MASK:   n.mask = wb_dat_i[0];
          MBDMA_OFS_SWREQ:  n.swreq = n.swreq | wb_dat_i[1:0];
          MBDMA_OFS_CHAN:
          begin
            if (wb_dat_i[MBDMA_KEEP_BIT] && r.stall)
              n.stall = 1'b0;
            if (wb_dat_i[MBDMA_ENABLE_BIT] && r.glob_en && !r.active)
            begin
              n.active     = 1'b1;
              n.src_init   = r.src;
              n.cnt        = 16'h0000;
              n.swin       = 16'h0000;
              n.dwin       = 16'h0000;
              n.desc_used  = 1'b0;
              n.fidx       = 3'h0;
              n.desc_base  = {r.dscr[31:2], 2'b00};
              n.desc_layer = r.dscr[1:0];
              n.fsm        = (r.dscr[31:2] != 30'h0000_0000) ? MBDMA_FETCH : MBDMA_SWAIT;
            end
            else if (!wb_dat_i[MBDMA_ENABLE_BIT])
            begin
              n.active   = 1'b0;
              n.stall    = 1'b0;
              n.mreq.cyc = 1'b0;
              n.fsm      = MBDMA_IDLE;
            end
          end
          default:
          begin
          end
        endcase
      end
      if (wb_we_i)
      begin
        case (wb_adr_i)
          MBDMA_OFS_SRC:     n.src = merge(r.src, wb_dat_i, wb_sel_i);
          MBDMA_OFS_DST:     n.dst = merge(r.dst, wb_dat_i, wb_sel_i);
          MBDMA_OFS_NEXT:    n.dscr = merge(r.dscr, wb_dat_i, wb_sel_i);
          MBDMA_OFS_CTL1:    n.ctl1 = merge(r.ctl1, wb_dat_i, wb_sel_i);
          MBDMA_OFS_CTL2:    n.ctl2 = merge(r.ctl2, wb_dat_i, wb_sel_i);
          MBDMA_OFS_CFG:     n.cfg = merge(r.cfg, wb_dat_i, wb_sel_i);
          MBDMA_OFS_SSTRIDE: n.sstride = merge(r.sstride, wb_dat_i, wb_sel_i);
          MBDMA_OFS_DSTRIDE: n.dstride = merge(r.dstride, wb_dat_i, wb_sel_i);
          default:
          begin
          end
        endcase
      end
    end

    // dropping the global enable stops the channel at once
    if (!n.glob_en && r.active)
    begin
      n.active   = 1'b0;
      n.stall    = 1'b0;
      n.mreq.cyc = 1'b0;
      n.fsm      = MBDMA_IDLE;
    end

    // a hardware event in the clearing cycle survives the read
    n.ev_buf   = n.ev_buf | set_buf;
    n.ev_chain = n.ev_chain | set_chain;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r     <= '0;
      r.fsm <= MBDMA_IDLE;
    end
    else
      r <= n;
  end

  // outputs straight from the state flops
  assign wb_dat_o      = r.wb_dat;
  assign wb_ack_o      = r.wb_ack;
  assign m_req_o       = r.mreq;
  assign src_ack_o     = r.src_ack;
  assign dst_ack_o     = r.dst_ack;
  assign src_hs_sel_o  = r.cfg[MBDMA_SHSEL_LSB +: 4];
  assign dst_hs_sel_o  = r.cfg[MBDMA_DHSEL_LSB +: 4];
  assign chan_active_o = r.active;

endmodule

`default_nettype wire

// >>> test/mbdma_channel_sva.sv
// port assertions for the multi-buffer dma channel
`default_nettype none
module mbdma_channel_sva
  import mbdma_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire mbdma_mreq_t m_req_o,
  input wire logic        m_ack_i,
  input wire logic        src_ack_o,
  input wire logic        chan_active_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire en_wr;
  // --------------------------------
  // checks
  // --------------------------------
  // write of bit 0 to global or channel enable
  assign en_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[7:3] == 5'h00 && wb_dat_i[0];
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack too long");
  unmapped_zero_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h30 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  req_hold_a: assert property (m_req_o.cyc && !m_ack_i |=> !m_req_o.cyc || $stable(m_req_o))
    else $error("master request moved");
  req_gap_a: assert property (m_req_o.cyc && m_ack_i |=> !m_req_o.cyc)
    else $error("no idle after master ack");
  idle_master_a: assert property (!chan_active_o && !$past(chan_active_o) |-> !m_req_o.cyc)
    else $error("request from idle channel");
  start_cause_a: assert property ($rose(chan_active_o) |-> $past(en_wr) || $past(en_wr, 2))
    else $error("start without enable write");
  src_ack_a: assert property (src_ack_o |-> $past(m_ack_i) && !$past(m_req_o.we))
    else $error("source ack without source read");
  cover property (src_ack_o);
  cover property ($fell(chan_active_o));
  cover property (m_req_o.cyc && m_req_o.we && m_ack_i);
endmodule

bind mbdma_channel mbdma_channel_sva mbdma_channel_sva_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .m_req_o, .m_ack_i, .src_ack_o, .chan_active_o);
`default_nettype wire

// >>> test/mbdma_mem_model.sv
// word memory standing on the channel's bus master port
`default_nettype none
module mbdma_mem_model
  import mbdma_pkg::*;
(
  input  wire logic        clk_i,
  input  wire mbdma_mreq_t req_i,
  output logic      [31:0] dat_o,
  output logic             ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [256];
  logic [31:0] rdat = 32'h0;
  logic [1:0]  waits = 2'h0;
  logic        slow = 1'b0;
  // --------------------------------
  // answer
  // --------------------------------
  // every other access waits three cycles, so slow slaves are seen too
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    if (req_i.cyc && ack_o !== 1'b1)
      if (waits != 2'h0)
        waits <= waits - 2'h1;
      else
      begin
        ack_o <= 1'b1;
        rdat <= mem[req_i.adr[9:2]];
        if (req_i.we)
          mem[req_i.adr[9:2]] <= req_i.dat;
        slow <= !slow;
        waits <= slow ? 2'h0 : 2'h3;
      end
  end
  // idle data lines carry the inverse, never a stale word
  assign dat_o = ack_o ? rdat : ~rdat;
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the multi-buffer dma channel
`default_nettype none
module tb_top
  import mbdma_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} mbdma_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  mbdma_mreq_t m_req_o;
  logic [31:0] m_dat_i;
  logic        m_ack_i;
  logic        src_req_i = 1'b0;
  logic        src_ack_o;
  logic [3:0]  src_hs_sel_o;
  logic        dst_ack_o;
  logic [3:0]  dst_hs_sel_o;
  logic        chan_active_o;
  logic [3:0]  wl = 4'h0;
  logic [31:0] rd;
  int          failures = 0;
  int          compares = 0;
  int          acks = 0;
  int          hits = 0;
  mbdma_row_t  rows [9] = '{
    '{8'h08, 32'h1, 32'h1}, '{8'h10, 32'h1234, 32'h1234}, '{8'h14, 32'h5678, 32'h5678},
    '{8'h18, 32'h300, 32'h300}, '{8'h1C, 32'h22000010, 32'h22000010}, '{8'h20, 32'h80400011, 32'h80400011},
    '{8'h24, 32'h32255, 32'h32255}, '{8'h28, 32'h40010, 32'h40010}, '{8'h34, 32'hFFFFFFFF, 32'h0}};

  mbdma_channel mbdma_channel_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .m_req_o, .m_dat_i, .m_ack_i, .src_req_i, .dst_req_i(1'b0), .src_ack_o,
    .dst_ack_o, .src_hs_sel_o, .dst_hs_sel_o, .chan_active_o);
  mbdma_mem_model mbdma_mem_model_i (.clk_i, .req_i(m_req_o), .dat_o(m_dat_i), .ack_o(m_ack_i));

  always #10 clk_i = ~clk_i;

  // peripheral asks again after each ack; counts acks and write-back layers
  always @(posedge clk_i)
  begin
    src_req_i <= chan_active_o && !src_ack_o;
    acks <= acks + int'(src_ack_o) + int'(dst_ack_o);
    hits <= hits + int'(m_ack_i);
    if (m_req_o.cyc && m_ack_i && m_req_o.we && m_req_o.adr[9:8] == 2'h3)
      wl[{m_req_o.adr[5], 1'b0} +: 2] <= m_req_o.layer;
  end

  // --------------------------------
  // tasks
  // --------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; request held until ack is seen
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    failures += int'(n == 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // poll status, bounded, until it reads the expected value
  task automatic wait_stat(input logic [31:0] e);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, 8'h04, 32'h0);
      n++;
    end
    while (rd !== e && n < 300);
    chk(rd, e);
  endtask
  task automatic put(input logic [7:0] i, input logic [31:0] v);
    mbdma_mem_model_i.mem[i] = v;
  endtask
  function automatic logic [31:0] mem(input logic [7:0] i);
    return mbdma_mem_model_i.mem[i];
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard, far beyond the sequence length
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      bus(1'b0, rows[i].a, 32'h0);
      chk(rd, 32'h0);
    end
    // replay source, contiguous destination, peripheral source, stalling
    put(8'h40, 32'h11110001);
    put(8'h41, 32'h22220002);
    put(8'h60, 32'h0BAD0BAD);
    bus(1'b0, 8'h0C, 32'h0);
    bus(1'b1, 8'h10, 32'h100);
    bus(1'b1, 8'h14, 32'h200);
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b1, 8'h1C, 32'h22000002);
    bus(1'b1, 8'h20, 32'h80400000);
    bus(1'b1, 8'h24, 32'h10205);
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h04, 32'h1);
    repeat (20) @(posedge clk_i);
    chk(32'(hits), 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h04, 32'h1);
    wait_stat(32'h3);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h1);
    chk(mem(8'h80), 32'h11110001);
    chk(mem(8'h81), 32'h22220002);
    chk(32'(acks), 32'h2);
    chk(32'(src_hs_sel_o), 32'h5);
    repeat (30) @(posedge clk_i);
    wait_stat(32'h3);
    bus(1'b1, 8'h20, 32'h00400000);
    bus(1'b1, 8'h04, 32'h3);
    wait_stat(32'h0);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h3);
    chk(mem(8'h82), 32'h11110001);
    chk(mem(8'h83), 32'h22220002);
    chk(32'(acks), 32'h4);
    // replay source, linked destination, mask cleared, no stall
    for (int k = 0; k < 2; k++)
    begin
      put(8'hC0 + 8'(8 * k), 32'h180);
      put(8'hC1 + 8'(8 * k), 32'h240 + 32'(64 * k));
      put(8'hC2 + 8'(8 * k), 32'h22000002);
      put(8'hC3 + 8'(8 * k), 32'h0);
      put(8'hC4 + 8'(8 * k), k == 0 ? 32'h322 : 32'h0);
    end
    bus(1'b0, 8'h0C, 32'h0);
    bus(1'b1, 8'h18, 32'h301);
    bus(1'b1, 8'h24, 32'h10000);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h04, 32'h1);
    wait_stat(32'h0);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h3);
    chk(mem(8'h90), 32'h11110001);
    chk(mem(8'h91), 32'h22220002);
    chk(mem(8'hA0), 32'h11110001);
    chk(mem(8'hA1), 32'h22220002);
    chk(mem(8'hC2), 32'hA2000002);
    chk(mem(8'hCA), 32'hA2000002);
    chk(32'(wl), 32'h9);
    chk(32'(acks), 32'h4);
    // linked source, contiguous destination, software-paced peripheral sink
    put(8'hD0, 32'h100);
    put(8'hD1, 32'h3C0);
    put(8'hD2, 32'h22000002);
    put(8'hD3, 32'h00200000);
    put(8'hD4, 32'h0);
    bus(1'b1, 8'h14, 32'h380);
    bus(1'b1, 8'h18, 32'h340);
    bus(1'b1, 8'h24, 32'h20050);
    bus(1'b1, 8'h04, 32'h1);
    repeat (2)
    begin
      bus(1'b1, 8'h30, 32'h2);
      repeat (60) @(posedge clk_i);
    end
    wait_stat(32'h0);
    chk(mem(8'hE0), 32'h11110001);
    chk(mem(8'hE1), 32'h22220002);
    chk(mem(8'hD2), 32'hA2000002);
    chk(32'(acks), 32'h6);
    chk(32'(dst_hs_sel_o), 32'h5);
    tally_and_finish();
  end
endmodule
`default_nettype wire
